// ### bar_readout.sv
// Pixel array readout sequencer with APB registers and output FIFO
`timescale 1ns/1ps
module bar_readout #(
  parameter int FIFO_DEPTH = bar_pkg::FIFO_DEPTH
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [10:0] arr_row,
  output logic      [10:0] arr_col,
  output logic             arr_read,
  output logic      [10:0] arr_reset_row,
  output logic             arr_reset_stb,
  input  wire logic [9:0]  adc_data,
  output logic      [9:0]  blk_data,
  output logic             blk_valid,
  output logic      [9:0]  pix_data,
  output logic      [1:0]  pix_color,
  output logic             line_valid,
  output logic             frame_valid,
  output logic             pix_valid,
  input  wire logic        pix_ready
);
  localparam int CW = bar_pkg::CNT_W;
  localparam int AW = bar_pkg::ADDR_W;
  localparam int PW = bar_pkg::PIX_W;
  localparam int WW = bar_pkg::WORD_W;

  logic [15:0]   ctrl;
  logic [15:0]   hblank;
  logic [15:0]   vblank;
  logic [15:0]   exposure;
  logic [15:0]   frames;
  logic [PW-1:0] blk_level;
  logic [CW-1:0] ws_c;
  logic [CW-1:0] ww_c;
  logic [CW-1:0] ws_r;
  logic [CW-1:0] ww_r;
  logic          mir_c;
  logic          mir_r;
  logic [CW-1:0] next_ws_c;
  logic [CW-1:0] next_ww_c;
  logic [CW-1:0] next_ws_r;
  logic [CW-1:0] next_ww_r;
  logic [CW-1:0] col_cnt;
  logic [CW-1:0] row_cnt;
  logic [CW-1:0] col_last;
  logic [CW-1:0] row_last;
  logic [CW-1:0] frame_rows;
  logic [CW-1:0] phys_col;
  logic [CW-1:0] phys_row;
  logic [CW:0]   rst_sum;
  logic [CW-1:0] rst_tgt;
  logic [CW-1:0] rst_phys;
  logic          col_wrap;
  logic          row_wrap;
  logic          run;
  logic          step;
  logic          frame_start;
  logic          in_cols;
  logic          in_rows;
  logic          in_win_c;
  logic          in_win_r;
  logic          lv_pos;
  logic          is_black;
  bar_pkg::bar_color_e color;
  logic          f_in_ready;
  logic [WW-1:0] f_in_data;
  logic          f_out_valid;
  logic [WW-1:0] f_out_data;
  logic [PW+1:0] blk_diff;
  logic [PW+1:0] blk_step;
  logic [15:0]   rd16;
  logic          addr_ok;
  logic          addr_rw;

  // Mirrored index inside the window; the window keeps its normal start parity
  function automatic logic [CW-1:0] phys_map(input logic [CW-1:0] sc,
                                            input logic [CW-1:0] ws,
                                            input logic [CW-1:0] w,
                                            input logic          mir);
    if (mir && sc >= ws && sc < ws + w) begin
      phys_map = (ws << 1) + w - sc;
    end else begin
      phys_map = sc;
    end
  endfunction

  assign run         = ctrl[bar_pkg::CTRL_RUN];
  assign step        = run && f_in_ready;
  assign col_last    = bar_pkg::COLS - 17'h00001 + CW'(hblank);
  assign row_last    = bar_pkg::ROWS - 17'h00001 + CW'(vblank);
  assign frame_rows  = bar_pkg::ROWS + CW'(vblank);
  assign frame_start = !run || (col_wrap && row_wrap);

  bar_wrap_counter #(.W(CW)) u_col (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (!run),
    .en      (step),
    .last    (col_last),
    .count   (col_cnt),
    .wrap    (col_wrap)
  );

  // Rows advance only after a whole line; one row is read at a time
  bar_wrap_counter #(.W(CW)) u_row (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (!run),
    .en      (col_wrap),
    .last    (row_last),
    .count   (row_cnt),
    .wrap    (row_wrap)
  );

  // Window geometry; full readout ignores mirroring so it never touches black columns
  always_comb begin
    next_ws_c = bar_pkg::WIN_COL;
    next_ww_c = bar_pkg::WIN_W;
    next_ws_r = bar_pkg::WIN_ROW;
    next_ww_r = bar_pkg::WIN_H;
    if (ctrl[bar_pkg::CTRL_FULL]) begin
      next_ws_c = bar_pkg::FIRST_COL;
      next_ww_c = bar_pkg::FULL_W;
      next_ws_r = bar_pkg::FIRST_ROW;
      next_ww_r = bar_pkg::FULL_H;
    end else if (ctrl[bar_pkg::CTRL_BOUNDARY]) begin
      next_ws_c = bar_pkg::WIN_COL - bar_pkg::BOUNDARY;
      next_ww_c = bar_pkg::WIN_W + bar_pkg::BOUNDARY + bar_pkg::BOUNDARY;
      next_ws_r = bar_pkg::WIN_ROW - bar_pkg::BOUNDARY;
      next_ww_r = bar_pkg::WIN_H + bar_pkg::BOUNDARY + bar_pkg::BOUNDARY;
    end
  end

  // Geometry is taken only at frame start so a frame is never torn
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ws_c  <= bar_pkg::WIN_COL;
      ww_c  <= bar_pkg::WIN_W;
      ws_r  <= bar_pkg::WIN_ROW;
      ww_r  <= bar_pkg::WIN_H;
      mir_c <= 1'b0;
      mir_r <= 1'b0;
    end else if (frame_start) begin
      ws_c  <= next_ws_c;
      ww_c  <= next_ww_c;
      ws_r  <= next_ws_r;
      ww_r  <= next_ww_r;
      mir_c <= ctrl[bar_pkg::CTRL_MIR_COL] && !ctrl[bar_pkg::CTRL_FULL];
      mir_r <= ctrl[bar_pkg::CTRL_MIR_ROW] && !ctrl[bar_pkg::CTRL_FULL];
    end
  end

  assign in_cols  = col_cnt < bar_pkg::COLS;
  assign in_rows  = row_cnt < bar_pkg::ROWS;
  assign in_win_c = col_cnt >= ws_c && col_cnt < ws_c + ww_c;
  assign in_win_r = row_cnt >= ws_r && row_cnt < ws_r + ww_r;
  assign lv_pos   = in_cols && in_rows && in_win_c && in_win_r;
  assign phys_col = phys_map(col_cnt, ws_c, ww_c, mir_c);
  assign phys_row = phys_map(row_cnt, ws_r, ww_r, mir_r);
  assign arr_col  = phys_col[AW-1:0];
  assign arr_row  = phys_row[AW-1:0];
  assign arr_read = step && in_cols && in_rows;

  // Colour from physical parity; mirroring keeps an even start, so phase holds
  always_comb begin
    if (!phys_row[0]) begin
      color = phys_col[0] ? bar_pkg::RED : bar_pkg::GREEN_RED_ROW;
    end else begin
      color = phys_col[0] ? bar_pkg::GREEN_BLUE_ROW : bar_pkg::BLUE;
    end
  end

  // Blanking words carry zero data so the host cannot mistake them for pixels
  assign f_in_data = {in_win_r, lv_pos, color, lv_pos ? adc_data : 10'h000};

  bar_fifo #(.WIDTH(WW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (run),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (pix_ready),
    .out_data  (f_out_data)
  );

  assign pix_valid   = f_out_valid;
  assign frame_valid = f_out_valid && f_out_data[WW-1];
  assign line_valid  = f_out_valid && f_out_data[WW-2];
  assign pix_color   = f_out_data[PW+1:PW];
  assign pix_data    = f_out_data[PW-1:0];

  assign is_black = in_cols && in_rows &&
                    (col_cnt < bar_pkg::BLACK_LEFT || col_cnt >= bar_pkg::BLACK_RCOL ||
                     row_cnt < bar_pkg::BLACK_ROWS || row_cnt >= bar_pkg::BLACK_BROW);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk_valid <= 1'b0;
      blk_data  <= 10'h000;
    end else begin
      blk_valid <= step && is_black;
      blk_data  <= adc_data;
    end
  end

  // Running black estimate; slow filter trades settling time for low noise
  assign blk_diff = {2'h0, adc_data} - {2'h0, blk_level};
  assign blk_step = $signed(blk_diff) >>> bar_pkg::BLK_SHIFT;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk_level <= 10'h000;
    end else if (step && is_black) begin
      blk_level <= PW'({2'h0, blk_level} + blk_step);
    end
  end

  // Row reset leads the read row by the exposure count, wrapping over the frame
  assign rst_sum  = {1'b0, row_cnt} + (CW + 1)'(exposure);
  assign rst_tgt  = (rst_sum >= {1'b0, frame_rows}) ? CW'(rst_sum - {1'b0, frame_rows})
                                                     : rst_sum[CW-1:0];
  assign rst_phys = phys_map(rst_tgt, ws_r, ww_r, mir_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arr_reset_stb <= 1'b0;
      arr_reset_row <= 11'h000;
    end else begin
      arr_reset_stb <= step && col_cnt == '0 && rst_tgt < bar_pkg::ROWS;
      arr_reset_row <= rst_phys[AW-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frames <= 16'h0000;
    end else if (col_wrap && row_wrap) begin
      frames <= frames + 16'h0001;
    end
  end

  // APB slave: read data latched in setup, zero wait states
  assign pready  = 1'b1;
  assign addr_rw = paddr == bar_pkg::OFF_CTRL || paddr == bar_pkg::OFF_HBLANK ||
                   paddr == bar_pkg::OFF_VBLANK || paddr == bar_pkg::OFF_EXPOSURE;
  assign addr_ok = addr_rw || paddr == bar_pkg::OFF_STATUS ||
                   paddr == bar_pkg::OFF_BLACK || paddr == bar_pkg::OFF_FRAMES;

  always_comb begin
    if (paddr == bar_pkg::OFF_CTRL) begin
      rd16 = ctrl;
    end else if (paddr == bar_pkg::OFF_HBLANK) begin
      rd16 = hblank;
    end else if (paddr == bar_pkg::OFF_VBLANK) begin
      rd16 = vblank;
    end else if (paddr == bar_pkg::OFF_EXPOSURE) begin
      rd16 = exposure;
    end else if (paddr == bar_pkg::OFF_STATUS) begin
      rd16 = {in_win_r, run, 3'h0, row_cnt[AW-1:0]};
    end else if (paddr == bar_pkg::OFF_BLACK) begin
      rd16 = {6'h00, blk_level};
    end else if (paddr == bar_pkg::OFF_FRAMES) begin
      rd16 = frames;
    end else begin
      rd16 = 16'h0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata  <= {16'h0000, rd16};
      pslverr <= !addr_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl     <= bar_pkg::RST_CTRL;
      hblank   <= bar_pkg::RST_HBLANK;
      vblank   <= bar_pkg::RST_VBLANK;
      exposure <= bar_pkg::RST_EXPOSURE;
    end else if (psel && penable && pwrite) begin
      if (paddr == bar_pkg::OFF_CTRL) begin
        ctrl <= {11'h000, pwdata[4:0]};
      end else if (paddr == bar_pkg::OFF_HBLANK) begin
        hblank <= pwdata[15:0];
      end else if (paddr == bar_pkg::OFF_VBLANK) begin
        vblank <= pwdata[15:0];
      end else if (paddr == bar_pkg::OFF_EXPOSURE) begin
        exposure <= pwdata[15:0];
      end
    end
  end

  sequence s_line_end;
    step && col_cnt == col_last;
  endsequence

  sequence s_line_start;
    col_cnt == '0;
  endsequence

  a_line_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    s_line_end |=> s_line_start)
    else $error("column counter did not wrap after blanking");
  a_pixel_rate: assert property (@(posedge pclk) disable iff (!presetn)
    (step && col_cnt != col_last) |=> col_cnt == $past(col_cnt) + 17'h00001)
    else $error("column did not advance one per clock");
  a_black_route: assert property (@(posedge pclk) disable iff (!presetn)
    (step && in_rows && col_cnt < bar_pkg::BLACK_LEFT) |=> blk_valid)
    else $error("black column sample not routed");
  a_black_right: assert property (@(posedge pclk) disable iff (!presetn)
    (step && lv_pos) |-> (phys_col < bar_pkg::BLACK_RCOL && !is_black))
    else $error("black pixel inside image");
  a_default_window: assert property (@(posedge pclk) disable iff (!presetn)
    (step && lv_pos && !mir_c && ws_c == bar_pkg::WIN_COL)
      |-> (phys_col >= 17'h0003c && phys_col < 17'h0067c))
    else $error("default window column out of range");
  a_default_geom: assert property (@(posedge pclk) disable iff (!presetn)
    (frame_start && !ctrl[bar_pkg::CTRL_FULL] && !ctrl[bar_pkg::CTRL_BOUNDARY])
      |=> (ws_c == 17'h0003c && ww_c == 17'h00640 &&
           ws_r == 17'h0001c && ww_r == 17'h004b0))
    else $error("default window geometry wrong");
  a_mirror_shift: assert property (@(posedge pclk) disable iff (!presetn)
    (step && lv_pos && mir_c) |-> (phys_col > ws_c && phys_col <= ws_c + ww_c))
    else $error("mirrored region not shifted by one");
  a_first_color: assert property (@(posedge pclk) disable iff (!presetn)
    (step && lv_pos && col_cnt == ws_c && row_cnt == ws_r)
      |-> (f_in_data[PW+1:PW] == bar_pkg::GREEN_RED_ROW))
    else $error("first image pixel colour changed");
  a_blank_low: assert property (@(posedge pclk) disable iff (!presetn)
    (step && !in_cols) |-> (f_in_data[WW-2] == 1'b0 && f_in_data[PW-1:0] == 10'h000))
    else $error("line valid or data set in blanking");
  a_frame_cover: assert property (@(posedge pclk) disable iff (!presetn)
    line_valid |-> frame_valid)
    else $error("line valid outside frame valid");
  a_reset_lead: assert property (@(posedge pclk) disable iff (!presetn)
    (step && col_cnt == '0 && in_rows && !mir_r && rst_sum < {1'b0, bar_pkg::ROWS})
      |=> (arr_reset_stb && arr_reset_row == $past(arr_row) + $past(exposure[10:0])))
    else $error("row reset not exposure rows ahead of read row");
endmodule

// ### bar_pkg.sv
// Constants, register map and types for the pixel array readout sequencer
// Overview of operation
// - Rows are reset then read; exposure is the reset-to-read row lead
// - Every pixel sample and stream word carries a 10-bit value
// - Shielded pixel samples feed the offset correction path and black level
// - Control and status registers are 16 bits wide, host configures readout
// - Row and column counters cover 1688 columns by 1256 rows
// - Columns 0 to 51 and first and last 20 rows are black
// - The last four columns are black and never in the image
// - Default window is 1600 by 1200 starting at row 28, column 60
// - Boundary option widens the window by four pixels on every side
// - Each mirrored direction shifts the read region by one pixel
// - Even rows carry green and red, odd rows blue and green
// - Even columns carry green and blue, odd columns red and green
// - Mirrored readout keeps the output colour sequence unchanged
// - Rows are read one at a time; full readout starts at column 52, row 20
// - Horizontal and vertical blanking lengths are set by the host
// - Line valid is high only for image samples, low in blanking
// - One pixel sample is produced per clock cycle
package bar_pkg;
  localparam int PIX_W      = 10;
  localparam int REG_W      = 16;
  localparam int CNT_W      = 17;
  localparam int ADDR_W     = 11;
  localparam int FIFO_DEPTH = 4;
  localparam int WORD_W     = PIX_W + 4;
  localparam int BLK_SHIFT  = 6;

  localparam logic [CNT_W-1:0] COLS        = 17'h00698;
  localparam logic [CNT_W-1:0] ROWS        = 17'h004e8;
  localparam logic [CNT_W-1:0] BLACK_LEFT  = 17'h00034;
  localparam logic [CNT_W-1:0] BLACK_RIGHT = 17'h00004;
  localparam logic [CNT_W-1:0] BLACK_ROWS  = 17'h00014;
  localparam logic [CNT_W-1:0] WIN_COL     = 17'h0003c;
  localparam logic [CNT_W-1:0] WIN_ROW     = 17'h0001c;
  localparam logic [CNT_W-1:0] WIN_W       = 17'h00640;
  localparam logic [CNT_W-1:0] WIN_H       = 17'h004b0;
  localparam logic [CNT_W-1:0] BOUNDARY    = 17'h00004;
  localparam logic [CNT_W-1:0] FIRST_COL   = 17'h00034;
  localparam logic [CNT_W-1:0] FIRST_ROW   = 17'h00014;
  localparam logic [CNT_W-1:0] BLACK_RCOL  = COLS - BLACK_RIGHT;
  localparam logic [CNT_W-1:0] BLACK_BROW  = ROWS - BLACK_ROWS;
  localparam logic [CNT_W-1:0] FULL_W      = COLS - BLACK_LEFT - BLACK_RIGHT;
  localparam logic [CNT_W-1:0] FULL_H      = ROWS - BLACK_ROWS - BLACK_ROWS;

  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_HBLANK   = 8'h04;
  localparam logic [7:0] OFF_VBLANK   = 8'h08;
  localparam logic [7:0] OFF_EXPOSURE = 8'h0c;
  localparam logic [7:0] OFF_STATUS   = 8'h10;
  localparam logic [7:0] OFF_BLACK    = 8'h14;
  localparam logic [7:0] OFF_FRAMES   = 8'h18;

  localparam int CTRL_RUN      = 0;
  localparam int CTRL_MIR_ROW  = 1;
  localparam int CTRL_MIR_COL  = 2;
  localparam int CTRL_BOUNDARY = 3;
  localparam int CTRL_FULL     = 4;

  localparam logic [REG_W-1:0] RST_CTRL     = 16'h0001;
  localparam logic [REG_W-1:0] RST_HBLANK   = 16'h0040;
  localparam logic [REG_W-1:0] RST_VBLANK   = 16'h0008;
  localparam logic [REG_W-1:0] RST_EXPOSURE = 16'h0100;

  typedef enum logic [1:0] {
    GREEN_RED_ROW,
    RED,
    BLUE,
    GREEN_BLUE_ROW
  } bar_color_e;
endpackage

// ### bar_wrap_counter.sv
// Wrapping counter with programmable last value
`timescale 1ns/1ps
module bar_wrap_counter #(
  parameter int W = 17
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         clr,
  input  wire logic         en,
  input  wire logic [W-1:0] last,
  output logic      [W-1:0] count,
  output logic              wrap
);
  assign wrap = en && (count == last);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (clr || wrap) begin
      count <= '0;
    end else if (en) begin
      count <= count + 1'b1;
    end
  end
endmodule

// ### bar_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
module bar_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 4
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [AW:0]   FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      fill;
  logic             push;
  logic             pop;

  assign in_ready  = (fill != FULL);
  assign out_valid = (fill != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        fill <= fill + 1'b1;
      end else if (pop && !push) begin
        fill <= fill - 1'b1;
      end
    end
  end

  a_fifo_fill_bound: assert property (@(posedge pclk) disable iff (!presetn)
    (fill == FULL && !out_ready) |=> (fill == FULL && !in_ready))
    else $error("fifo fill changed while full and stalled");
endmodule

// ### bar_host_model.sv
// Host side model that takes raw pixel words, with selectable stalls
`timescale 1ns/1ps
module bar_host_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] mode,
  output logic            pix_ready
);
  // Mode 0 stalls one cycle in sixteen, 1 stalls always, 2 never stalls
  // Rare stalls keep the scan near full rate, so a frame start stays in budget
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pix_ready <= 1'b0;
    end else begin
      pix_ready <= (mode == 2'h2) || (mode == 2'h0 && $urandom_range(15) != 0);
    end
  end
endmodule

// ### test_bar_readout.sv
// Self-checking bench for the pixel array readout sequencer
`timescale 1ns/1ps
module test_bar_readout;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        pready;
  logic        pslverr;
  logic        arr_read;
  logic        arr_reset_stb;
  logic        blk_valid;
  logic        pix_valid;
  logic        pix_ready;
  logic        line_valid;
  logic        frame_valid;
  logic        er;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [31:0] expo;
  logic [10:0] arr_row;
  logic [10:0] arr_col;
  logic [10:0] arr_reset_row;
  logic [10:0] c0;
  logic [9:0]  adc_data;
  logic [9:0]  blk_data;
  logic [9:0]  pix_data;
  logic [9:0]  salt;
  logic [1:0]  pix_color;
  logic [1:0]  mode;
  logic [11:0] exp_q[$];
  logic [11:0] pw;
  logic [7:0]  offs[4] = '{bar_pkg::OFF_CTRL, bar_pkg::OFF_HBLANK, bar_pkg::OFF_VBLANK,
                           bar_pkg::OFF_EXPOSURE};
  logic [15:0] rsts[4] = '{bar_pkg::RST_CTRL, bar_pkg::RST_HBLANK, bar_pkg::RST_VBLANK,
                           bar_pkg::RST_EXPOSURE};
  int          n_fail = 0;
  int          check_count = 0;
  int          cyc = 0;

  // Array contents: a scrambled function of the address, so order slips show
  function automatic logic [9:0] pix_fn(input int r, input int c);
    return 10'(r * 5 + c * 3);
  endfunction
  function automatic logic [11:0] pix_word(input int r, input int c);
    return {r[0], c[0], pix_fn(r, c) ^ salt};
  endfunction
  assign adc_data = pix_fn(int'(arr_row), int'(arr_col)) ^ salt;

  bar_readout #(.FIFO_DEPTH(bar_pkg::FIFO_DEPTH)) u_bar_readout (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .arr_row(arr_row), .arr_col(arr_col), .arr_read(arr_read),
    .arr_reset_row(arr_reset_row), .arr_reset_stb(arr_reset_stb), .adc_data(adc_data),
    .blk_data(blk_data), .blk_valid(blk_valid), .pix_data(pix_data),
    .pix_color(pix_color), .line_valid(line_valid), .frame_valid(frame_valid),
    .pix_valid(pix_valid), .pix_ready(pix_ready)
  );
  bar_host_model u_bar_host_model (
    .pclk(pclk), .presetn(presetn), .mode(mode), .pix_ready(pix_ready)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic complete_run();
    $display("Checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] want, input string what);
    check_count++;
    if (seen !== want) begin
      n_fail++;
      $display("FAIL %0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Stop the scan, drain, note n words of row r and the first eight of row r2, then restart
  task automatic run_scn(input logic [4:0] ctl, input int r, input int c, input int n,
                         input int d, input int r2);
    apb(1'b1, bar_pkg::OFF_CTRL, {27'h0, ctl});
    while (pix_valid !== 1'b0) @(negedge pclk);
    for (int i = 0; i < n; i++) exp_q.push_back(pix_word(r, c + d * i));
    for (int i = 0; i < 8; i++) exp_q.push_back(pix_word(r2, c + d * i));
    apb(1'b1, bar_pkg::OFF_CTRL, {27'h0, ctl | 5'h01});
    while (exp_q.size() != 0) @(posedge pclk);
  endtask

  // Monitor takes the oldest note whenever an image word is accepted
  always @(posedge pclk) begin
    if (pix_valid === 1'b1 && pix_ready === 1'b1 && line_valid === 1'b1) begin
      chk(32'(frame_valid), 32'h1, "frame valid");
      if (exp_q.size() > 0) begin
        pw = exp_q.pop_front();
        chk(32'({pix_color, pix_data}), 32'(pw), "pixel");
      end
    end
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 98000) begin
      n_fail++;
      complete_run();
    end
  end

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mode = 2'h0;
    presetn = 1'b0;
    void'($urandom(32'h4a5b));
    salt = 10'($urandom);
    expo = 32'($urandom_range(1000, 1));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, offs[i], 32'h0);
      chk(rd, {16'h0, rsts[i]}, "reset value");
    end
    apb(1'b1, bar_pkg::OFF_HBLANK, 32'h00000002);
    apb(1'b0, bar_pkg::OFF_HBLANK, 32'h0);
    chk(rd, 32'h00000002, "hblank");
    apb(1'b1, bar_pkg::OFF_EXPOSURE, expo);
    apb(1'b1, bar_pkg::OFF_FRAMES, 32'h0000ffff);
    apb(1'b0, bar_pkg::OFF_FRAMES, 32'h0);
    chk(rd, 32'h0, "read only");
    apb(1'b0, 8'h1c, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    apb(1'b0, 8'h02, 32'h0);
    chk({31'h0, er}, 32'h1, "unaligned error");
    // Restart scan: row reset strobe leads by the exposure, black feed, rate, stall
    apb(1'b1, bar_pkg::OFF_CTRL, 32'h0);
    while (pix_valid !== 1'b0) @(negedge pclk);
    apb(1'b1, bar_pkg::OFF_CTRL, 32'h1);
    for (int i = 0; i < 100 && arr_reset_stb !== 1'b1; i++) @(negedge pclk);
    chk(32'(arr_reset_stb), 32'h1, "reset strobe");
    chk(32'(arr_reset_row), 32'(expo[10:0]), "reset row");
    @(posedge pclk);
    mode <= 2'h2;
    repeat (3) @(negedge pclk);
    c0 = arr_col;
    repeat (8) @(negedge pclk);
    chk(32'(arr_col), 32'(c0 + 11'h008), "one per cycle");
    chk(32'(blk_valid), 32'h1, "black feed");
    chk(32'(blk_data), 32'(pix_fn(0, int'(c0) + 7) ^ salt), "black data");
    chk(32'(arr_read), 32'h1, "array read");
    @(posedge pclk);
    mode <= 2'h1;
    repeat (8) @(negedge pclk);
    c0 = arr_col;
    repeat (4) @(negedge pclk);
    chk(32'(arr_col), 32'(c0), "scan frozen");
    chk(32'(pix_valid), 32'h1, "fifo full");
    chk(32'(arr_read), 32'h0, "read held");
    apb(1'b0, bar_pkg::OFF_STATUS, 32'h0);
    chk(rd, 32'h00004000, "status");
    @(posedge pclk);
    mode <= 2'h0;
    run_scn(5'h10, 20, 52, 1632, 1, 21);
    run_scn(5'h0e, 1232, 1664, 1608, -1, 1231);
    complete_run();
  end
endmodule
